// *** oclt_map.vh ***
/*
  Constants for the overcurrent latchoff and trim block: register offsets,
  field positions, reset codes and timing counts.
  Assumes a 100 MHz mclk and an 8-bit command-code register port.
*/
`ifndef OCLT_MAP_VH
`define OCLT_MAP_VH

// ------------------------------------------------------------
// Register offsets (command codes)
// ------------------------------------------------------------
`define OCLT_OFS_DELAY      8'hd4
`define OCLT_OFS_LL_CAL     8'hde
`define OCLT_OFS_LL_SET     8'hdf
`define OCLT_OFS_OC_SCALE   8'he2
`define OCLT_OFS_BAL_FIRST  8'he3
`define OCLT_OFS_BAL_LAST   8'he6

// ------------------------------------------------------------
// Fields and reset codes
// ------------------------------------------------------------
`define OCLT_CODE_MSB       4
`define OCLT_DLY_MSB        2
`define OCLT_RST_CODE5      8'h10
`define OCLT_RST_DELAY      8'h03
`define OCLT_RST_LL         8'h10

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define OCLT_CLK_MHZ        100
`define OCLT_STEP_US        500
`define OCLT_LATCH_MULT     3'h4
`define OCLT_SOFT_MV        200

`endif

// *** oclt_delay_timer.v ***
/*
  Shared delay timer: counts mult programmed intervals of (code+1) steps each.
  Assumes start is a one-cycle pulse from logic on mclk.
*/
module oclt_delay_timer #(
  parameter STEP_CYCLES = 50000
) (
  // Clock and reset
  input wire       mclk,
  input wire       reset_n,
  // Control
  input wire       start,
  input wire       abort,
  input wire [2:0] code,
  input wire [2:0] mult,
  // Result
  output reg       busy,
  output reg       done
);
  reg [31:0] stepCnt_r;
  reg [5:0]  stepsLeft_r;
  // Eight codes times a multiplier below eight never exceeds six bits.
  wire [5:0] stepsTotal = ({3'h0, code} + 6'h01) * {3'h0, mult};

  always @(posedge mclk) begin
    done <= 1'b0;
    if (!reset_n || abort) begin
      busy        <= 1'b0;
      stepCnt_r   <= 32'h0;
      stepsLeft_r <= 6'h0;
    end else if (start) begin
      busy        <= 1'b1;
      stepCnt_r   <= 32'h0;
      stepsLeft_r <= stepsTotal - 6'h01;
    end else if (busy) begin
      if (stepCnt_r == STEP_CYCLES - 1) begin
        stepCnt_r <= 32'h0;
        if (stepsLeft_r == 6'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          stepsLeft_r <= stepsLeft_r - 6'h1;
        end
      end else begin
        stepCnt_r <= stepCnt_r + 32'h1;
      end
    end
  end
endmodule

// *** oclt_core.v ***
/*
  Overcurrent latchoff sequencer and trim code registers of a multi-phase
  regulator controller. Registers are reached by command code over an
  8-bit port fed by the serial transaction layer on mclk.
  Assumes analog comparator flags arrive asynchronously from pins.
*/
// How it works
// [RL1] Threshold scale field spans 50% to 146.7% of resistor-set limit.
// [RL2] Threshold code steps about 3.3%; code 0x10 is 100% and reset.
// [RL3] Overcurrent after final blanking starts latchoff delay; persisting fault shuts down.
// [RL4] Latchoff delay is four startup delay intervals on the shared timer.
// [RL5] Overcurrent during startup waits until blanking phase completes before latchoff.
// [RL6] Phases keep switching during delay; cleared fault abandons latchoff.
// [RL7] Latch clears only on supply cycle or enable low pulse.
// [RL8] Output below 200 mV during startup clamps control voltage to 1.5 V.
// [RL9] Load-line is sum of calibration and set command codes.
// [RL10] Load-line codes are five bits, 0 to 100 percent, reset 0x10.
// [RL11] Four phase balance commands at consecutive codes trim each phase.
// [RL12] Balance code five bits: 0 is 3.75, 0x10 is 5, 0x1f 6.25.
// [RL13] Delay code three bits, 0.5 ms steps, reset 011 gives 2 ms.
// [RL14] Latched off: PWM held inactive and overcurrent ignored until recovery.
`include "oclt_map.vh"
module oclt_core #(
  parameter STEP_CYCLES = `OCLT_STEP_US * `OCLT_CLK_MHZ
) (
  // Clock and reset
  input wire        mclk,
  input wire        reset_n,
  // Register port
  input wire        regWrite,
  input wire        regRead,
  input wire [7:0]  regAddr,
  input wire [7:0]  regWdata,
  output reg [7:0]  regRdata,
  output reg        regAck,
  // Analog status pins
  input wire        enablePin,
  input wire        overcurrentIn,
  input wire        outputLow,
  input wire        blankMaskDone,
  // Control outputs
  output reg        pwmEnable,
  output reg        latchedOff,
  output reg        startupDone,
  output reg        softLimitClamp,
  output reg [4:0]  ocScaleCode,
  output reg [5:0]  loadLineSum,
  output reg [19:0] balanceCodes
);
  localparam ST_OFF   = 6'h01;
  localparam ST_TD1   = 6'h02;
  localparam ST_RAMP  = 6'h04;
  localparam ST_TD5   = 6'h08;
  localparam ST_RUN   = 6'h10;
  localparam ST_LATCH = 6'h20;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  always @(posedge mclk) begin
    if (!reset_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {blankMaskDone, outputLow, overcurrentIn, enablePin};
      sync2_r <= sync1_r;
    end
  end
  wire enS   = sync2_r[0];
  wire ocS   = sync2_r[1];
  wire lowS  = sync2_r[2];
  wire maskS = sync2_r[3];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] delay_r;
  reg [7:0] llCal_r;
  reg [7:0] llSet_r;
  reg [7:0] ocScale_r;
  reg [7:0] bal_r [0:3];
  integer i;
  wire balHit = (regAddr >= `OCLT_OFS_BAL_FIRST) && (regAddr <= `OCLT_OFS_BAL_LAST);
  wire [7:0] balOfs = regAddr - `OCLT_OFS_BAL_FIRST;
  wire [1:0] balIdx = balOfs[1:0];

  always @(posedge mclk) begin
    if (!reset_n) begin
      delay_r   <= `OCLT_RST_DELAY; // RL13
      llCal_r   <= `OCLT_RST_LL; // RL10
      llSet_r   <= `OCLT_RST_LL;
      ocScale_r <= `OCLT_RST_CODE5; // RL2
      for (i = 0; i < 4; i = i + 1) bal_r[i] <= `OCLT_RST_CODE5; // RL12
    end else if (regWrite) begin
      case (regAddr)
        `OCLT_OFS_DELAY:    delay_r   <= {5'h0, regWdata[`OCLT_DLY_MSB:0]};
        `OCLT_OFS_LL_CAL:   llCal_r   <= {3'h0, regWdata[`OCLT_CODE_MSB:0]};
        `OCLT_OFS_LL_SET:   llSet_r   <= {3'h0, regWdata[`OCLT_CODE_MSB:0]};
        `OCLT_OFS_OC_SCALE: ocScale_r <= {3'h0, regWdata[`OCLT_CODE_MSB:0]}; // RL1
        default: begin
          if (balHit) bal_r[balIdx] <= {3'h0, regWdata[`OCLT_CODE_MSB:0]}; // RL11
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      regRdata <= 8'h0;
      regAck   <= 1'b0;
    end else begin
      regAck <= regRead | regWrite;
      case (regAddr)
        `OCLT_OFS_DELAY:    regRdata <= delay_r;
        `OCLT_OFS_LL_CAL:   regRdata <= llCal_r;
        `OCLT_OFS_LL_SET:   regRdata <= llSet_r;
        `OCLT_OFS_OC_SCALE: regRdata <= ocScale_r;
        default:            regRdata <= balHit ? bal_r[balIdx] : 8'h0;
      endcase
    end
  end

  // Trim codes go straight to the analog side, which decodes them.
  always @(posedge mclk) begin
    if (!reset_n) begin
      ocScaleCode  <= 5'h10;
      loadLineSum  <= 6'h20;
      balanceCodes <= {4{5'h10}};
    end else begin
      ocScaleCode  <= ocScale_r[4:0]; // RL1
      loadLineSum  <= {1'b0, llCal_r[4:0]} + {1'b0, llSet_r[4:0]}; // RL9
      balanceCodes <= {bal_r[3][4:0], bal_r[2][4:0], bal_r[1][4:0], bal_r[0][4:0]}; // RL11
    end
  end

  // ------------------------------------------------------------
  // Startup and latchoff sequencer
  // ------------------------------------------------------------
  reg  [5:0] state_r;
  reg  [5:0] state_nxt;
  reg        enPrev_r;
  reg        tStart;
  reg        tAbort;
  reg  [2:0] tMult;
  reg        latchRun_r;
  wire       tBusy;
  wire       tDone;
  // A falling edge on enable, seen after synchronising, is the recovery pulse.
  wire       enFall = enPrev_r & ~enS;

  oclt_delay_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .mclk    (mclk),
    .reset_n (reset_n),
    .start   (tStart),
    .abort   (tAbort),
    .code    (delay_r[2:0]),
    .mult    (tMult),
    .busy    (tBusy),
    .done    (tDone)
  );

  always @* begin
    state_nxt = state_r;
    tStart    = 1'b0;
    tAbort    = 1'b0;
    tMult     = 3'h1;
    case (state_r)
      ST_OFF: begin
        if (enS) begin
          state_nxt = ST_TD1;
          tStart    = 1'b1;
        end
      end
      ST_TD1: begin
        if (tDone) state_nxt = ST_RAMP; // RL5
      end
      ST_RAMP: begin
        if (maskS) begin
          state_nxt = ST_TD5;
          tStart    = 1'b1;
        end
      end
      ST_TD5: begin
        if (tDone) state_nxt = ST_RUN; // RL5
      end
      ST_RUN: begin
        tMult = `OCLT_LATCH_MULT; // RL4
        if (ocS && !latchRun_r) tStart = 1'b1; // RL3
        else if (!ocS && latchRun_r) tAbort = 1'b1; // RL6
        else if (tDone && ocS) state_nxt = ST_LATCH; // RL3
      end
      ST_LATCH: state_nxt = ST_LATCH; // RL14
      default: state_nxt = ST_OFF;
    endcase
    if (!enS && state_r != ST_OFF) begin
      state_nxt = ST_OFF; // RL7
      tAbort    = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      state_r    <= ST_OFF;
      enPrev_r   <= 1'b0;
      latchRun_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      enPrev_r   <= enS;
      latchRun_r <= (state_nxt == ST_RUN) && (tStart || (latchRun_r && !tAbort && !tDone));
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      pwmEnable      <= 1'b0;
      latchedOff     <= 1'b0;
      startupDone    <= 1'b0;
      softLimitClamp <= 1'b0;
    end else begin
      // Switching continues through the latchoff delay.
      pwmEnable      <= (state_nxt == ST_RAMP) || (state_nxt == ST_TD5) ||
                        (state_nxt == ST_RUN); // RL6 RL14
      latchedOff     <= (state_nxt == ST_LATCH) && !enFall; // RL7
      startupDone    <= (state_nxt == ST_RUN);
      softLimitClamp <= lowS && ((state_nxt == ST_RAMP) || (state_nxt == ST_TD5)); // RL8
    end
  end
endmodule

// *** oclt_core_props.sv ***
/*
  Checker for oclt_core port behaviour.
  Assumes STEP_CYCLES=10 and delay code 3, so latchoff takes 160 cycles.
*/
module oclt_props #(parameter int LATCH_CYCLES = 160) (
  input wire logic        mclk, reset_n, regWrite, regRead, regAck, enablePin,
  input wire logic        overcurrentIn, outputLow, blankMaskDone, pwmEnable,
  input wire logic        latchedOff, startupDone, softLimitClamp,
  input wire logic [7:0]  regAddr, regWdata, regRdata,
  input wire logic [4:0]  ocScaleCode,
  input wire logic [5:0]  loadLineSum,
  input wire logic [19:0] balanceCodes
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Counts how long a fault has stood after startup; the pin lag gives a few cycles of slack.
  logic [9:0] ocRun_r;
  wire logic [4:0] wrCode = regWdata[4:0];
  always @(posedge mclk) begin
    ocRun_r <= (!reset_n || !overcurrentIn || !startupDone) ? 10'h000 : ocRun_r + 10'h001;
  end
  property p_rst; $rose(reset_n) |-> ocScaleCode == 5'h10 && balanceCodes == 20'h84210; endproperty
  a_rst: assert property (p_rst) else $error("bad reset codes");
  property p_scale; regWrite && regAddr == 8'he2 |-> ##2 ocScaleCode == $past(wrCode, 2); endproperty
  a_scale: assert property (p_scale) else $error("threshold code not taken");
  property p_bal; $changed(balanceCodes) |-> $past(regWrite, 2) && $past(regAddr, 2) inside {[8'he3:8'he6]}; endproperty
  a_bal: assert property (p_bal) else $error("balance codes changed alone");
  property p_off; latchedOff |-> !pwmEnable; endproperty
  a_off: assert property (p_off) else $error("phases on while latched");
  property p_latch; $rose(latchedOff) |-> $past(overcurrentIn) && $past(startupDone); endproperty
  a_latch: assert property (p_latch) else $error("latch without fault");
  property p_len; $rose(latchedOff) |-> ocRun_r inside {[LATCH_CYCLES-2:LATCH_CYCLES+6]}; endproperty
  a_len: assert property (p_len) else $error("latchoff delay length wrong");
  property p_run; startupDone && !latchedOff |-> pwmEnable; endproperty
  a_run: assert property (p_run) else $error("phases stopped while running");
  // The pin reaches the clamp through two sync stages and one output flop.
  property p_clamp; softLimitClamp |-> !startupDone && $past(outputLow, 3); endproperty
  a_clamp: assert property (p_clamp) else $error("clamp after startup");
  property p_clr; $fell(latchedOff) |-> !($past(enablePin) && $past(enablePin, 2) && $past(enablePin, 3)); endproperty
  a_clr: assert property (p_clr) else $error("latch cleared without enable low");
  c_latch: cover property ($rose(latchedOff));
  c_done: cover property ($rose(startupDone));
  c_clamp: cover property (softLimitClamp);
endmodule
bind oclt_core oclt_props #(.LATCH_CYCLES(160)) u_props (.mclk(mclk), .reset_n(reset_n),
  .regWrite(regWrite), .regRead(regRead), .regAck(regAck), .enablePin(enablePin),
  .overcurrentIn(overcurrentIn), .outputLow(outputLow), .blankMaskDone(blankMaskDone),
  .pwmEnable(pwmEnable), .latchedOff(latchedOff), .startupDone(startupDone),
  .softLimitClamp(softLimitClamp), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .ocScaleCode(ocScaleCode), .loadLineSum(loadLineSum),
  .balanceCodes(balanceCodes));

// *** oclt_host.sv ***
/*
  Host model: issues command-code register accesses on the register port.
  Assumes the design answers each request with regAck one cycle later, for as long as the request is held.
*/
module oclt_host (
  input  wire logic       mclk,
  input  wire logic       regAck,
  input  wire logic [7:0] regRdata,
  output logic            regWrite = 1'b0,
  output logic            regRead  = 1'b0,
  output logic [7:0]      regAddr  = 8'h00,
  output logic [7:0]      regWdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // The request is held until the acknowledge is sampled, then released.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge mclk);
    regAddr = a;
    regWdata = d;
    regWrite = w;
    regRead = !w;
    do @(posedge mclk); while (regAck !== 1'b1);
    q = regRdata;
    @(negedge mclk);
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask
endmodule

// *** oclt_core_tb.sv ***
/*
  Testbench for oclt_core: register codes and the latchoff sequence.
  Assumes STEP_CYCLES=10, so one delay interval of code 3 is 40 cycles.
*/
module oclt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, enablePin = 0, overcurrentIn = 0, outputLow = 0, blankMaskDone = 0;
  wire logic regWrite, regRead, regAck, pwmEnable, latchedOff, startupDone, softLimitClamp;
  wire logic [7:0] regAddr, regWdata, regRdata;
  wire logic [4:0] ocScaleCode;
  wire logic [5:0] loadLineSum;
  wire logic [19:0] balanceCodes;
  int num_errors = 0, comparisons = 0;
  initial forever #5 mclk = ~mclk;
  oclt_host host (.mclk(mclk), .regAck(regAck), .regRdata(regRdata), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
  oclt_core #(.STEP_CYCLES(10)) uut (.mclk(mclk), .reset_n(reset_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regAck(regAck), .enablePin(enablePin), .overcurrentIn(overcurrentIn),
    .outputLow(outputLow), .blankMaskDone(blankMaskDone), .pwmEnable(pwmEnable),
    .latchedOff(latchedOff), .startupDone(startupDone), .softLimitClamp(softLimitClamp),
    .ocScaleCode(ocScaleCode), .loadLineSum(loadLineSum), .balanceCodes(balanceCodes));
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    chk("regRdata", e, q);
  endtask
  task automatic t_reset;
    chk("balanceCodes", 20'h84210, balanceCodes);
    chk("loadLineSum", 20'h20, loadLineSum);
    rd(8'hd4, 8'h03);
    rd(8'he2, 8'h10);
    rd(8'h00, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    wr(8'he2, 8'he5);
    tick(2);
    chk("ocScaleCode", 20'h05, ocScaleCode);
    rd(8'he2, 8'h05);
    wr(8'hde, 8'h1f);
    wr(8'hdf, 8'hff);
    tick(2);
    chk("loadLineSum", 20'h3e, loadLineSum);
    wr(8'hd4, 8'hff);
    rd(8'hd4, 8'h07);
    wr(8'hd4, 8'h03);
    wr(8'he3, 8'h00);
    wr(8'he4, 8'h1f);
    wr(8'he5, 8'h10);
    wr(8'he6, 8'h05);
    tick(2);
    chk("balanceCodes", {5'h05, 5'h10, 5'h1f, 5'h00}, balanceCodes);
    wr(8'h00, 8'hab);
    rd(8'h00, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_latch;
    outputLow = 1;
    overcurrentIn = 1;
    enablePin = 1;
    for (int i = 0; i < 300 && pwmEnable !== 1'b1; i++) tick(1);
    chk("softLimitClamp", 20'h1, softLimitClamp);
    outputLow = 0;
    blankMaskDone = 1;
    for (int i = 0; i < 300 && startupDone !== 1'b1; i++) tick(1);
    chk("startupDone", 20'h1, startupDone);
    chk("softLimitClamp", 20'h0, softLimitClamp);
    chk("latchedOff", 20'h0, latchedOff);
    tick(150);
    chk("latchedOff", 20'h0, latchedOff);
    for (int i = 0; i < 40 && latchedOff !== 1'b1; i++) tick(1);
    chk("latchedOff", 20'h1, latchedOff);
    chk("pwmEnable", 20'h0, pwmEnable);
    overcurrentIn = 0;
    tick(10);
    chk("latchedOff", 20'h1, latchedOff);
    enablePin = 0;
    tick(6);
    chk("latchedOff", 20'h0, latchedOff);
    $display("t_latch done");
  endtask
  task automatic t_abort;
    enablePin = 1;
    for (int i = 0; i < 300 && startupDone !== 1'b1; i++) tick(1);
    chk("startupDone", 20'h1, startupDone);
    overcurrentIn = 1;
    tick(100);
    chk("pwmEnable", 20'h1, pwmEnable);
    // A short clear must restart the delay, so the old expiry passes harmlessly.
    overcurrentIn = 0;
    tick(20);
    overcurrentIn = 1;
    tick(100);
    chk("latchedOff", 20'h0, latchedOff);
    tick(100);
    chk("latchedOff", 20'h1, latchedOff);
    $display("t_abort done");
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    report_and_stop();
  end
  initial begin
    tick(4);
    reset_n = 1;
    t_reset();
    t_regs();
    t_latch();
    t_abort();
    report_and_stop();
  end
endmodule
